// file: sim/sga_cpu_model.sv
// CPU-side partner: issues one byte access at a time on the guard's CPU bus.
// Assumes the one-cycle answer of the guard with its clock enable held high.
`timescale 1ns/1ps
module sga_cpu_model (
   input wire logic clk_in,
   output logic req_out,
   output logic we_out,
   output logic fetch_out,
   output logic [19:0] addr_out,
   output logic [7:0] wdata_out,
   input wire logic ack_in,
   input wire logic rvalid_in,
   input wire logic rd_en_in,
   input wire logic wr_en_in,
   input wire logic reset_req_in,
   input wire logic [7:0] rdata_in
);
   // Idle bus at time zero
   initial begin
      req_out = 1'b0;
      we_out = 1'b0;
      fetch_out = 1'b0;
      addr_out = 20'h0_0000;
      wdata_out = 8'h00;
   end

   // Whole-byte access only, so the control register never sees bit writes
   task automatic access(input logic w, input logic f, input logic [19:0] a,
                         input logic [7:0] d, output logic [12:0] res);
      @(negedge clk_in);
      req_out <= 1'b1;
      we_out <= w;
      fetch_out <= f;
      addr_out <= a;
      wdata_out <= d;
      // Answer is fixed at one cycle, so one edge later everything has landed
      @(negedge clk_in);
      res = {ack_in, rvalid_in, rd_en_in, wr_en_in, reset_req_in,
             rvalid_in ? rdata_in : 8'h00};
      req_out <= 1'b0;
      // Released lines flip so stale values cannot pass for held ones
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
endmodule

// file: sim/sga_guard_bench.sv
// Self-checking bench for the RAM/register write guard and access checker.
// Assumes the guard's default parameters: 8 KB RAM, 128 KB flash.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module sga_guard_bench;
   import sga_pkg::*;
   // Flags: ack, ctl read, mem read, mem write, reset request
   localparam logic [4:0] W = 5'h12, B = 5'h10, RD = 5'h14, CR = 5'h18;
   localparam logic [4:0] RDR = 5'h15, WRR = 5'h13;
   logic clk_sys_in = 1'b0, reset_in = 1'b1, ce_in = 1'b1, wdog = 1'b0;
   logic req, we, fetch, ack, rvalid, rd_en, wr_en, rr;
   logic [19:0] addr, maddr;
   logic [7:0] wdata, rdata, mwdata;
   int bad_count = 0, checks = 0;

   always #10 clk_sys_in = ~clk_sys_in;

   sga_guard i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in),
      .watchdog_option_enable_in(wdog), .cpu_req_in(req), .cpu_we_in(we),
      .cpu_fetch_in(fetch), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
      .cpu_ack_out(ack), .ctl_rdata_out(rdata), .ctl_rvalid_out(rvalid),
      .mem_rd_en_out(rd_en), .mem_wr_en_out(wr_en), .mem_addr_out(maddr),
      .mem_wdata_out(mwdata), .reset_req_out(rr));

   sga_cpu_model i_cpu (.clk_in(clk_sys_in), .req_out(req), .we_out(we),
      .fetch_out(fetch), .addr_out(addr), .wdata_out(wdata), .ack_in(ack),
      .rvalid_in(rvalid), .rd_en_in(rd_en), .wr_en_in(wr_en),
      .reset_req_in(rr), .rdata_in(rdata));

   // One access and its judged answer
   task automatic acc(input logic w, input logic f, input logic [19:0] a,
                      input logic [7:0] d, input logic [4:0] fl, input logic [7:0] ed);
      logic [12:0] r;
      i_cpu.access(w, f, a, d, r);
      `CHK(r, {fl, ed})
      // Memory side carries a registered copy of every access until the next edge
      `CHK({maddr, mwdata}, {a, d})
   endtask

   // Control writes are judged by reading back, not by their flags
   task automatic wctl(input logic [7:0] v);
      logic [12:0] r;
      i_cpu.access(1'b1, 1'b0, CTL_ADDR, v, r);
   endtask

   task automatic t_off();
      acc(0, 0, CTL_ADDR, 8'h00, CR, 8'h00);
      acc(0, 0, FLASH_TOP_128K, 8'h00, RD, 8'h00);
      wdog = 1'b1;
      acc(0, 1, FLASH_TOP_128K, 8'h00, RDR, 8'h00);
      wdog = 1'b0;
      $display("detection off done");
   endtask

   task automatic t_ram();
      logic [19:0] lens [4];
      lens = '{RAM_LEN_128, RAM_LEN_128, RAM_LEN_256, RAM_LEN_512};
      for (int c = 0; c < 4; c++) begin
         wctl({2'h0, c[1:0], 4'h0});
         acc(0, 0, CTL_ADDR, 8'h00, CR, {2'h0, c[1:0], 4'h0});
         acc(1, 0, RAM_START_8K + lens[c] - 20'h0_0001, 8'hA5, c == 0 ? W : B, 8'h00);
         acc(1, 0, RAM_START_8K + lens[c], 8'h5A, W, 8'h00);
         acc(0, 0, RAM_START_8K, 8'h00, RD, 8'h00);
      end
      $display("ram guard done");
   endtask

   task automatic t_sfr();
      wctl(8'h07);
      acc(1, 0, 20'hF_0030, 8'h11, B, 8'h00);
      acc(1, 0, 20'hF_007F, 8'h11, B, 8'h00);
      acc(1, 0, 20'hF_FF00, 8'h22, W, 8'h00);
      acc(1, 0, 20'hF_FFD0, 8'h33, B, 8'h00);
      acc(1, 0, 20'hF_00F5, 8'h44, B, 8'h00);
      acc(0, 0, 20'hF_00F5, 8'h00, RD, 8'h00);
      acc(0, 0, 20'hF_0030, 8'h00, RD, 8'h00);
      wctl(8'h00);
      acc(1, 0, 20'hF_0030, 8'h11, W, 8'h00);
      acc(1, 0, 20'hF_FFE0, 8'h33, W, 8'h00);
      $display("register guard done");
   endtask

   // Low clock enable: a control write is not taken and every answer flag holds at idle
   task automatic t_ce();
      logic [12:0] r;
      @(negedge clk_sys_in);
      ce_in = 1'b0;
      i_cpu.access(1'b1, 1'b0, CTL_ADDR, 8'h30, r);
      `CHK(r, 13'h0000)
      ce_in = 1'b1;
      acc(0, 0, CTL_ADDR, 8'h00, CR, 8'h00);
      $display("clock enable done");
   endtask

   task automatic t_on();
      wctl(8'hFF);
      acc(0, 0, CTL_ADDR, 8'h00, CR, 8'hB7);
      wctl(8'h00);
      acc(0, 0, CTL_ADDR, 8'h00, CR, 8'h80);
      acc(0, 0, FLASH_TOP_128K, 8'h00, RDR, 8'h00);
      acc(0, 1, FLASH_TOP_128K - 20'h0_0001, 8'h00, RD, 8'h00);
      acc(0, 0, 20'hE_FFFF, 8'h00, RDR, 8'h00);
      acc(1, 0, 20'h0_0010, 8'h5A, WRR, 8'h00);
      $display("detection on done");
   endtask

   task automatic t_rst();
      reset_in = 1'b1;
      @(negedge clk_sys_in);
      reset_in = 1'b0;
      acc(0, 0, CTL_ADDR, 8'h00, CR, 8'h00);
      acc(0, 0, FLASH_TOP_128K, 8'h00, RD, 8'h00);
      $display("second reset done");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard well above the expected run length
   initial begin
      repeat (5000) @(posedge clk_sys_in);
      bad_count++;
      $display("mismatch at %0t got %h exp %h (timeout)", $time, checks, 5000);
      stop_test();
   end

   initial begin
      repeat (16) @(negedge clk_sys_in);
      reset_in = 1'b0;
      t_off();
      t_ram();
      t_sfr();
      t_ce();
      t_on();
      t_rst();
      stop_test();
   end
endmodule

// file: src/sga_addr_class.sv
// Address classifier: which guard group or prohibited area an address falls in.
// Purely combinational; the caller registers everything it derives from it.
`timescale 1ns/1ps
module sga_addr_class #(
   parameter bit RAM_8K = 1'b1,
   parameter bit FLASH_128K = 1'b1,
   parameter int NRANGE = 2,
   parameter logic [NRANGE-1:0][19:0] PORT_LO = '{20'hF_0030, 20'hF_0060},
   parameter logic [NRANGE-1:0][19:0] PORT_HI = '{20'hF_005F, 20'hF_007F},
   parameter logic [NRANGE-1:0][19:0] INT_LO = '{20'hF_FFD0, 20'hF_FFE0},
   parameter logic [NRANGE-1:0][19:0] INT_HI = '{20'hF_FFDF, 20'hF_FFEF},
   parameter logic [NRANGE-1:0][19:0] CLK_LO = '{20'hF_FFA0, 20'hF_00F0},
   parameter logic [NRANGE-1:0][19:0] CLK_HI = '{20'hF_FFA8, 20'hF_00F5},
   parameter logic [19:0] INV_RD_HI = 20'hE_FFFF,
   parameter logic [19:0] INV_WR_LO = 20'h0_0000,
   parameter logic [19:0] INV_WR_HI = 20'hE_FFFF
) (
   input wire logic [sga_pkg::ADDR_W-1:0] addr_in,
   input wire logic [1:0] ram_size_in,
   output logic port_hit_out,
   output logic int_hit_out,
   output logic clk_hit_out,
   output logic ram_guard_hit_out,
   output logic inv_rd_out,
   output logic inv_wr_out
);
   import sga_pkg::*;

   // Inclusive range test, shared by every table lookup
   function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo,
                                   input logic [19:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   wire [NRANGE-1:0] port_v;
   wire [NRANGE-1:0] int_v;
   wire [NRANGE-1:0] clk_v;

   // One comparator pair per table entry
   genvar g;
   generate
      for (g = 0; g < NRANGE; g++) begin : g_rng
         assign port_v[g] = in_rng(addr_in, PORT_LO[g], PORT_HI[g]);
         assign int_v[g] = in_rng(addr_in, INT_LO[g], INT_HI[g]);
         assign clk_v[g] = in_rng(addr_in, CLK_LO[g], CLK_HI[g]);
      end
   endgenerate

   // Port output data registers sit outside PORT tables, so stay writable
   assign port_hit_out = |port_v;
   assign int_hit_out = |int_v;
   assign clk_hit_out = |clk_v;

   // Guard region counts up from the RAM base chosen by RAM size
   wire [19:0] ram_base = RAM_8K ? RAM_START_8K : RAM_START_6K;
   wire [19:0] ram_len = (ram_size_in == RAM_GUARD_128) ? RAM_LEN_128 :
                         (ram_size_in == RAM_GUARD_256) ? RAM_LEN_256 : RAM_LEN_512;
   assign ram_guard_hit_out = (ram_size_in != RAM_GUARD_OFF) &&
                              in_rng(addr_in, ram_base, ram_base + ram_len - 20'h0_0001);

   // Prohibited areas; read floor sits just above the code flash
   wire [19:0] inv_rd_lo = FLASH_128K ? FLASH_TOP_128K : FLASH_TOP_64K;
   assign inv_rd_out = in_rng(addr_in, inv_rd_lo, INV_RD_HI);
   assign inv_wr_out = in_rng(addr_in, INV_WR_LO, INV_WR_HI);
endmodule

// file: src/sga_guard.sv
// Top of the RAM/special-register write guard and invalid access checker.
// Sits between the CPU and memory; one access per enabled cycle, answered next cycle.
`timescale 1ns/1ps
module sga_guard #(
   parameter bit RAM_8K = 1'b1,
   parameter bit FLASH_128K = 1'b1,
   parameter logic [19:0] INV_RD_HI = 20'hE_FFFF,
   parameter logic [19:0] INV_WR_LO = 20'h0_0000,
   parameter logic [19:0] INV_WR_HI = 20'hE_FFFF
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic watchdog_option_enable_in,
   input wire logic cpu_req_in,
   input wire logic cpu_we_in,
   input wire logic cpu_fetch_in,
   input wire logic [sga_pkg::ADDR_W-1:0] cpu_addr_in,
   input wire logic [sga_pkg::DATA_W-1:0] cpu_wdata_in,
   output logic cpu_ack_out,
   output logic [sga_pkg::DATA_W-1:0] ctl_rdata_out,
   output logic ctl_rvalid_out,
   output logic mem_rd_en_out,
   output logic mem_wr_en_out,
   output logic [sga_pkg::ADDR_W-1:0] mem_addr_out,
   output logic [sga_pkg::DATA_W-1:0] mem_wdata_out,
   output logic reset_req_out
);
   import sga_pkg::*;

   logic [7:0] ctl_r;
   logic [7:0] ctl_nxt;
   logic port_hit, int_hit, clk_hit, ram_hit, inv_rd, inv_wr;

   sga_addr_class #(
      .RAM_8K(RAM_8K),
      .FLASH_128K(FLASH_128K),
      .INV_RD_HI(INV_RD_HI),
      .INV_WR_LO(INV_WR_LO),
      .INV_WR_HI(INV_WR_HI)
   ) u_class (
      .addr_in(cpu_addr_in),
      .ram_size_in(ctl_r[CTL_RAM_HI_BIT:CTL_RAM_LO_BIT]),
      .port_hit_out(port_hit),
      .int_hit_out(int_hit),
      .clk_hit_out(clk_hit),
      .ram_guard_hit_out(ram_hit),
      .inv_rd_out(inv_rd),
      .inv_wr_out(inv_wr)
   );

   // Access decode; the control register sits inside a PORT table range but is decoded apart from guarded writes
   wire ctl_sel = cpu_req_in && (cpu_addr_in == CTL_ADDR);
   wire ctl_wr = ctl_sel && cpu_we_in;
   wire wr_req = cpu_req_in && cpu_we_in && !ctl_sel;
   wire rd_req = cpu_req_in && !cpu_we_in && !ctl_sel;

   // Write blocked by any guard group
   wire blocked = ram_hit
                  || (ctl_r[CTL_PORT_BIT] && port_hit)
                  || (ctl_r[CTL_INT_BIT] && int_hit)
                  || (ctl_r[CTL_CLK_BIT] && clk_hit);

   // Detection on by software enable or by the watchdog option strap
   wire detect_on = ctl_r[CTL_EN_BIT] || watchdog_option_enable_in;
   wire bad_access = (rd_req || (cpu_req_in && cpu_fetch_in)) ? inv_rd :
                     wr_req ? inv_wr : 1'b0;
   wire reset_req_nxt = cpu_req_in && detect_on && bad_access;

   // Fixed-zero bits never store; enable bit only ORs in new ones
   always_comb begin
      ctl_nxt = ctl_r;
      if (ctl_wr) begin
         ctl_nxt = cpu_wdata_in & 8'hB7;
         ctl_nxt[CTL_EN_BIT] = ctl_r[CTL_EN_BIT] | cpu_wdata_in[CTL_EN_BIT];
      end
   end

   // Control register; reset wins over the clock enable
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ctl_r <= CTL_RESET;
      end else if (ce_in) begin
         ctl_r <= ctl_nxt;
      end
   end

   // Registered bus answer; blocked writes still acknowledge
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         cpu_ack_out <= 1'b0;
         ctl_rvalid_out <= 1'b0;
         ctl_rdata_out <= 8'h00;
         mem_rd_en_out <= 1'b0;
         mem_wr_en_out <= 1'b0;
         mem_addr_out <= 20'h0_0000;
         mem_wdata_out <= 8'h00;
         reset_req_out <= 1'b0;
      end else if (ce_in) begin
         cpu_ack_out <= cpu_req_in;
         ctl_rvalid_out <= ctl_sel && !cpu_we_in;
         ctl_rdata_out <= ctl_r;
         mem_rd_en_out <= rd_req;
         mem_wr_en_out <= wr_req && !blocked;
         mem_addr_out <= cpu_addr_in;
         mem_wdata_out <= cpu_wdata_in;
         reset_req_out <= reset_req_nxt;
      end
   end

   // Checks; inputs sampled on an enabled edge, answer seen one edge later
   property p_reset_clear;
      @(posedge clk_sys_in) reset_in |=> (ctl_r == 8'h00);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("control not cleared");

   property p_zero_bits;
      @(posedge clk_sys_in) disable iff (reset_in) (ctl_r[6] == 1'b0) && (ctl_r[3] == 1'b0);
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("fixed zero bit set");

   property p_set_only;
      @(posedge clk_sys_in) disable iff (reset_in) ctl_r[7] |=> ctl_r[7];
   endproperty
   a_set_only: assert property (p_set_only) else $error("enable bit cleared");

   property p_ctl_write;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && ctl_wr |=> (ctl_r[5:4] == $past(cpu_wdata_in[5:4])) &&
                              (ctl_r[2:0] == $past(cpu_wdata_in[2:0]));
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

   property p_ram_block;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && wr_req && ram_hit |=> !mem_wr_en_out && cpu_ack_out;
   endproperty
   a_ram_block: assert property (p_ram_block) else $error("guarded RAM written");

   property p_ram_read;
      @(posedge clk_sys_in) disable iff (reset_in) ce_in && rd_req |=> mem_rd_en_out;
   endproperty
   a_ram_read: assert property (p_ram_read) else $error("read not passed");

   property p_port_block;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && wr_req && port_hit && ctl_r[2] |=> !mem_wr_en_out;
   endproperty
   a_port_block: assert property (p_port_block) else $error("port config written");

   property p_int_block;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && wr_req && int_hit && ctl_r[1] |=> !mem_wr_en_out;
   endproperty
   a_int_block: assert property (p_int_block) else $error("interrupt reg written");

   property p_clk_block;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && wr_req && clk_hit && ctl_r[0] |=> !mem_wr_en_out;
   endproperty
   a_clk_block: assert property (p_clk_block) else $error("clock reg written");

   property p_free_write;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && wr_req && !ram_hit && !port_hit && !int_hit && !clk_hit
         |=> mem_wr_en_out && (mem_addr_out == $past(cpu_addr_in));
   endproperty
   a_free_write: assert property (p_free_write) else $error("free write dropped");

   property p_detect;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && cpu_req_in && bad_access && (ctl_r[7] || watchdog_option_enable_in)
         |=> reset_req_out;
   endproperty
   a_detect: assert property (p_detect) else $error("invalid access missed");

   property p_detect_off;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && !ctl_r[7] && !watchdog_option_enable_in |=> !reset_req_out;
   endproperty
   a_detect_off: assert property (p_detect_off) else $error("reset while detect off");

   // Every taken request is answered, blocked or not
   property p_ack;
      @(posedge clk_sys_in) disable iff (reset_in) ce_in && cpu_req_in |=> cpu_ack_out;
   endproperty
   a_ack: assert property (p_ack) else $error("access not acknowledged");

   // Guarded writes end quietly; a prohibited write still owes its reset request
   property p_blocked_quiet;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && wr_req && blocked && !inv_wr |=> cpu_ack_out && !mem_wr_en_out && !reset_req_out;
   endproperty
   a_blocked_quiet: assert property (p_blocked_quiet) else $error("blocked write not quiet");

   // Control read returns the value held when the read was taken
   property p_ctl_read;
      @(posedge clk_sys_in) disable iff (reset_in)
         ce_in && ctl_sel && !cpu_we_in |=> ctl_rvalid_out && (ctl_rdata_out == $past(ctl_r));
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");

   // Low clock enable must freeze the control register
   property p_freeze;
      @(posedge clk_sys_in) disable iff (reset_in) !ce_in |=> $stable(ctl_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("control moved while frozen");

   c_ram_block: cover property (@(posedge clk_sys_in) ce_in && wr_req && ram_hit);
   c_reset_req: cover property (@(posedge clk_sys_in) reset_req_out);
   c_port_block: cover property (@(posedge clk_sys_in)
                                 ce_in && wr_req && port_hit && ctl_r[2]);
   c_set_only: cover property (@(posedge clk_sys_in)
                               ce_in && ctl_r[7] && ctl_wr && !cpu_wdata_in[7]);
endmodule

// file: src/sga_pkg.sv
// Shared constants for the RAM and special-register guard with access checker.
// Assumes a 20-bit byte address space and 8-bit data on the CPU memory bus.
package sga_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   // Guard and access-check control register
   localparam logic [19:0] CTL_ADDR = 20'hF_0078;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam int CTL_EN_BIT = 7;
   localparam int CTL_RAM_HI_BIT = 5;
   localparam int CTL_RAM_LO_BIT = 4;
   localparam int CTL_PORT_BIT = 2;
   localparam int CTL_INT_BIT = 1;
   localparam int CTL_CLK_BIT = 0;
   // RAM guard size codes and region lengths in bytes
   localparam logic [1:0] RAM_GUARD_OFF = 2'h0;
   localparam logic [1:0] RAM_GUARD_128 = 2'h1;
   localparam logic [1:0] RAM_GUARD_256 = 2'h2;
   localparam logic [1:0] RAM_GUARD_512 = 2'h3;
   localparam logic [19:0] RAM_LEN_128 = 20'h0_0080;
   localparam logic [19:0] RAM_LEN_256 = 20'h0_0100;
   localparam logic [19:0] RAM_LEN_512 = 20'h0_0200;
   // RAM placement per RAM size
   localparam logic [19:0] RAM_START_8K = 20'hF_DF00;
   localparam logic [19:0] RAM_START_6K = 20'hF_E700;
   localparam logic [19:0] RAM_END = 20'hF_FEFF;
   // Lowest invalid read/fetch address per code flash size
   localparam logic [19:0] FLASH_TOP_128K = 20'h2_0000;
   localparam logic [19:0] FLASH_TOP_64K = 20'h1_0000;
endpackage
